// ### core/serial_port_core.sv
`timescale 1ns/1ps
module serial_port_core #(
    parameter int PERF_MODE  = 0,
    parameter int LANES      = serial_port_pkg::DEF_LANES,
    parameter int W          = serial_port_pkg::DEF_WIDTH,
    parameter int FIFO_DEPTH = serial_port_pkg::DEF_FIFO_DEPTH,
    parameter int FIFO_EN    = 1,
    parameter int SLAVES     = serial_port_pkg::DEF_SLAVES,
    parameter int HALF_CYC   = serial_port_pkg::SCK_HALF_CYC
) (
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  nrst,
    // configuration and status
    input  wire serial_port_pkg::cfg_t cfg,
    output serial_port_pkg::stat_t     stat,
    // host transmit queue
    input  wire logic                  wr_valid,
    output logic                       wr_ready,
    input  wire logic [31:0]           wr_data,
    // host receive queue
    output logic                       rd_valid,
    input  wire logic                  rd_ready,
    output logic [31:0]                rd_data,
    // serial pins
    input  wire logic                  sck_in,
    output logic                       sck_out,
    output logic                       sck_oe,
    input  wire logic                  slave_select_input,
    output logic [SLAVES-1:0]          ss_n_out,
    input  wire logic [3:0]            io_in,
    output logic [3:0]                 io_out,
    output logic [3:0]                 io_oe
);
    localparam int EW = $clog2(2 * W);
    localparam int DW = $clog2(HALF_CYC + 1);
    localparam logic [DW-1:0] TICK_AT = DW'(HALF_CYC - 1);

    generate
        if (!(LANES == 1 || LANES == 2 || LANES == 4)) begin : g_bad_lanes
            $error("LANES must be 1, 2 or 4");
        end
        if (W % 4 != 0 || W > serial_port_pkg::HOST_WIDTH) begin : g_bad_width
            $error("element width must be a multiple of 4, at most 32");
        end
        if (FIFO_DEPTH != serial_port_pkg::DEF_FIFO_DEPTH &&
            FIFO_DEPTH != serial_port_pkg::ALT_FIFO_DEPTH) begin : g_bad_depth
            $error("fifo depth must be 16 or 256");
        end
        if (SLAVES < 1 || SLAVES > serial_port_pkg::MAX_SLAVES) begin : g_bad_slaves
            $error("between 1 and 32 select outputs");
        end
        // input pins lag two flops, so a shorter half period samples stale data
        if (HALF_CYC < 3) begin : g_bad_half
            $error("serial half period below three cycles");
        end
    endgenerate

    serial_port_pkg::state_t     st_r, st_nxt;
    serial_port_pkg::lane_mode_t lane;
    serial_port_pkg::stat_t      stat_nxt;
    logic [DW-1:0]     div_r, div_nxt;
    logic [EW-1:0]     edge_r, edge_nxt, last_edge;
    logic [W-1:0]      sh_r, sh_nxt, rx_r, rx_nxt, rx_shift;
    logic              sck_r, sck_nxt, act_r, act_nxt;
    logic              hold_w_r, hold_w_nxt, hold_r_r, hold_r_nxt;
    logic [3:0]        io_nxt, oe_nxt;
    logic [SLAVES-1:0] ss_n_nxt;
    logic              sck_s1, sck_s2, sck_s3, ss_s1, ss_s2;
    logic [3:0]        io_s1, io_s2;
    logic              tx_valid, tx_pop, rx_ready, rx_push, rx_valid, rx_pop;
    logic [W-1:0]      tx_data, rx_data;
    logic              tick, sck_edge, lead_ev, trail_ev, smp_ev, drv_ev;
    logic              ss_sel, auto_eff, need_rx, start_ok, abort;
    logic              done_p, abort_p, in_bit, tx_in_ready;

    // pins from outside pass two flops before any use
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_s3 <= 1'b0;
            ss_s1  <= 1'b1;
            ss_s2  <= 1'b1;
            io_s1  <= 4'h0;
            io_s2  <= 4'h0;
        end else begin
            sck_s1 <= sck_in;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
            ss_s1  <= slave_select_input;
            ss_s2  <= ss_s1;
            io_s1  <= io_in;
            io_s2  <= io_s1;
        end
    end

    // host side: slave only, answers beats it is offered
    always_comb begin
        wr_ready   = tx_in_ready && (PERF_MODE != 0 || !hold_w_r);
        rd_valid   = rx_valid && (PERF_MODE != 0 || !hold_r_r);
        rx_pop     = rd_valid && rd_ready;
        hold_w_nxt = wr_valid && wr_ready;
        hold_r_nxt = rx_pop;
        rd_data    = serial_port_pkg::HOST_WIDTH'(rx_data);
    end

    stream_fifo #(.W(W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .in_valid  (wr_valid && wr_ready),
        .in_ready  (tx_in_ready),
        .in_data   (wr_data[W-1:0]),
        .out_valid (tx_valid),
        .out_ready (tx_pop),
        .out_data  (tx_data)
    );

    // rx full stalls the engine before the next element that stores receive data
    stream_fifo #(.W(W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .in_valid  (rx_push),
        .in_ready  (rx_ready),
        .in_data   (rx_nxt),
        .out_valid (rx_valid),
        .out_ready (rx_pop),
        .out_data  (rx_data)
    );

    // lane choice, clamped to what was built; slave is single lane
    always_comb begin
        lane = serial_port_pkg::LANE_ONE;
        if (cfg.master && cfg.lanes == serial_port_pkg::LANE_FOUR && LANES == 4)
            lane = serial_port_pkg::LANE_FOUR;
        else if (cfg.master && cfg.lanes == serial_port_pkg::LANE_TWO && LANES >= 2)
            lane = serial_port_pkg::LANE_TWO;
        case (lane)
            serial_port_pkg::LANE_TWO:  last_edge = EW'(W - 1);
            serial_port_pkg::LANE_FOUR: last_edge = EW'(W / 2 - 1);
            default:                    last_edge = EW'(2 * W - 1);
        endcase
        in_bit = cfg.master ? io_s2[1] : io_s2[0];
        case (lane)
            serial_port_pkg::LANE_TWO:  rx_shift = {rx_r[W-3:0], io_s2[1:0]};
            serial_port_pkg::LANE_FOUR: rx_shift = {rx_r[W-5:0], io_s2[3:0]};
            default:                    rx_shift = {rx_r[W-2:0], in_bit};
        endcase
        auto_eff = cfg.auto_ss && lane == serial_port_pkg::LANE_ONE;
        need_rx  = lane == serial_port_pkg::LANE_ONE || cfg.rx_dir;
        ss_sel   = !ss_s2;
        abort    = !cfg.master && !ss_sel;
        start_ok = cfg.enable && tx_valid && (rx_ready || !need_rx) &&
                   (cfg.master || ss_sel);
        tick     = div_r == TICK_AT;
        sck_edge = sck_s2 != sck_s3;
        if (cfg.master) begin
            lead_ev  = tick && sck_r == cfg.cpol;
            trail_ev = tick && sck_r != cfg.cpol;
        end else begin
            lead_ev  = sck_edge && sck_s3 == cfg.cpol;
            trail_ev = sck_edge && sck_s3 != cfg.cpol;
        end
        smp_ev = cfg.cpha ? trail_ev : lead_ev;
        drv_ev = cfg.cpha ? lead_ev : trail_ev;
    end

    // element engine
    always_comb begin
        st_nxt   = st_r;
        div_nxt  = div_r;
        sck_nxt  = sck_r;
        edge_nxt = edge_r;
        sh_nxt   = sh_r;
        rx_nxt   = rx_r;
        act_nxt  = act_r;
        tx_pop   = 1'b0;
        rx_push  = 1'b0;
        done_p   = 1'b0;
        abort_p  = 1'b0;
        case (st_r)
            serial_port_pkg::ST_IDLE: begin
                div_nxt = '0;
                if (cfg.master)
                    sck_nxt = cfg.cpol;
                if (start_ok) begin
                    st_nxt   = serial_port_pkg::ST_SHIFT;
                    edge_nxt = '0;
                    sh_nxt   = tx_data;
                    act_nxt  = 1'b1;
                end else begin
                    act_nxt = 1'b0;
                end
            end
            serial_port_pkg::ST_SHIFT: begin
                div_nxt = (tick || !cfg.master) ? '0 : div_r + 1'b1;
                if (abort) begin
                    // head stays queued, so reselect sends it again
                    st_nxt   = serial_port_pkg::ST_IDLE;
                    edge_nxt = '0;
                    abort_p  = 1'b1;
                end else if (lead_ev || trail_ev) begin
                    if (cfg.master)
                        sck_nxt = ~sck_r;
                    edge_nxt = edge_r + 1'b1;
                    if (smp_ev)
                        rx_nxt = rx_shift;
                    if (drv_ev && !(cfg.cpha && edge_r == '0)) begin
                        case (lane)
                            serial_port_pkg::LANE_TWO:  sh_nxt = {sh_r[W-3:0], 2'h0};
                            serial_port_pkg::LANE_FOUR: sh_nxt = {sh_r[W-5:0], 4'h0};
                            default:                    sh_nxt = {sh_r[W-2:0], 1'b0};
                        endcase
                    end
                    if (edge_r == last_edge) begin
                        done_p  = 1'b1;
                        tx_pop  = 1'b1;
                        rx_push = need_rx;
                        if (auto_eff && FIFO_EN == 0) begin
                            st_nxt  = serial_port_pkg::ST_GAP;
                            act_nxt = 1'b0;
                        end else begin
                            // idle decides at once whether the next element follows
                            st_nxt = serial_port_pkg::ST_IDLE;
                        end
                    end
                end
            end
            serial_port_pkg::ST_GAP: begin
                div_nxt = tick ? '0 : div_r + 1'b1;
                if (tick || !cfg.master)
                    st_nxt = serial_port_pkg::ST_IDLE;
            end
            default: st_nxt = serial_port_pkg::ST_IDLE;
        endcase
    end

    // pin drive, registered together with the serial clock
    always_comb begin
        io_nxt = 4'h0;
        oe_nxt = serial_port_pkg::OE_NONE;
        case (lane)
            serial_port_pkg::LANE_TWO: begin
                io_nxt = {2'h0, sh_nxt[W-1:W-2]};
                oe_nxt = cfg.rx_dir ? serial_port_pkg::OE_NONE
                                    : serial_port_pkg::OE_DUAL;
            end
            serial_port_pkg::LANE_FOUR: begin
                io_nxt = sh_nxt[W-1:W-4];
                oe_nxt = cfg.rx_dir ? serial_port_pkg::OE_NONE
                                    : serial_port_pkg::OE_QUAD;
            end
            default: begin
                if (cfg.master) begin
                    io_nxt = {3'h0, sh_nxt[W-1]};
                    oe_nxt = serial_port_pkg::OE_SINGLE;
                end else begin
                    io_nxt = {2'h0, sh_nxt[W-1], 1'b0};
                    oe_nxt = ss_sel ? serial_port_pkg::OE_SLAVE
                                    : serial_port_pkg::OE_NONE;
                end
            end
        endcase
        if (!cfg.enable)
            oe_nxt = serial_port_pkg::OE_NONE;
        stat_nxt.busy     = st_nxt != serial_port_pkg::ST_IDLE;
        stat_nxt.done     = done_p;
        stat_nxt.aborted  = abort_p;
        stat_nxt.tx_empty = !tx_valid;
    end

    // manual select holds value; software must toggle it between transfers
    for (genvar i = 0; i < SLAVES; i++) begin : g_ss
        assign ss_n_nxt[i] = !(cfg.enable && cfg.master && cfg.ss_value[i] &&
                               (act_nxt || !auto_eff));
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_r     <= serial_port_pkg::ST_IDLE;
            div_r    <= '0;
            sck_r    <= 1'b0;
            edge_r   <= '0;
            sh_r     <= '0;
            rx_r     <= '0;
            act_r    <= 1'b0;
            hold_w_r <= 1'b0;
            hold_r_r <= 1'b0;
            io_out   <= 4'h0;
            io_oe    <= serial_port_pkg::OE_NONE;
            ss_n_out <= '1;
            stat     <= '0;
            sck_out  <= 1'b0;
            sck_oe   <= 1'b0;
        end else begin
            st_r     <= st_nxt;
            div_r    <= div_nxt;
            sck_r    <= sck_nxt;
            edge_r   <= edge_nxt;
            sh_r     <= sh_nxt;
            rx_r     <= rx_nxt;
            act_r    <= act_nxt;
            hold_w_r <= hold_w_nxt;
            hold_r_r <= hold_r_nxt;
            io_out   <= io_nxt;
            io_oe    <= oe_nxt;
            ss_n_out <= ss_n_nxt;
            stat     <= stat_nxt;
            sck_out  <= sck_nxt;
            sck_oe   <= cfg.enable && cfg.master;
        end
    end

    property p_lite_single;
        @(posedge ref_clk) disable iff (!nrst)
        (PERF_MODE == 0 && wr_valid && wr_ready) |=> !wr_ready;
    endproperty
    a_lite_single: assert property (p_lite_single)
        else $error("lite port took back-to-back beats");

    property p_rd_holds;
        @(posedge ref_clk) disable iff (!nrst)
        (rd_valid && !rd_ready) |=> (rd_valid && $stable(rd_data));
    endproperty
    a_rd_holds: assert property (p_rd_holds)
        else $error("read answer withdrawn before taken");

    property p_burst;
        @(posedge ref_clk) disable iff (!nrst)
        (PERF_MODE != 0 && wr_valid && wr_ready) ##1 (wr_valid && tx_in_ready) |-> wr_ready;
    endproperty
    a_burst: assert property (p_burst)
        else $error("full port refused a burst beat");

    property p_single_oe;
        @(posedge ref_clk) disable iff (!nrst)
        (cfg.enable && cfg.master && lane == serial_port_pkg::LANE_ONE) |=>
            io_oe == serial_port_pkg::OE_SINGLE;
    endproperty
    a_single_oe: assert property (p_single_oe)
        else $error("single lane master pin enables wrong");

    property p_quad_rx;
        @(posedge ref_clk) disable iff (!nrst)
        (lane == serial_port_pkg::LANE_FOUR && cfg.rx_dir) |=> io_oe == 4'h0;
    endproperty
    a_quad_rx: assert property (p_quad_rx)
        else $error("quad read phase still drives pins");

    property p_manual_ss;
        @(posedge ref_clk) disable iff (!nrst)
        (cfg.enable && cfg.master && !auto_eff) ##1
            (cfg.enable && cfg.master && !auto_eff && $stable(cfg.ss_value)) ##1
            (cfg.enable && cfg.master && !auto_eff && $stable(cfg.ss_value)) |->
            ss_n_out == ~$past(cfg.ss_value[SLAVES-1:0]) && $stable(ss_n_out);
    endproperty
    a_manual_ss: assert property (p_manual_ss)
        else $error("manual select does not follow its value");

    property p_auto_gap;
        @(posedge ref_clk) disable iff (!nrst)
        (done_p && auto_eff && FIFO_EN == 0 && cfg.master) |=> ss_n_out == '1;
    endproperty
    a_auto_gap: assert property (p_auto_gap)
        else $error("automatic select not released after element");

    property p_idle_pol;
        @(posedge ref_clk) disable iff (!nrst)
        (st_r == serial_port_pkg::ST_IDLE && cfg.master) ##1
            (st_r == serial_port_pkg::ST_IDLE) |-> sck_out == $past(cfg.cpol);
    endproperty
    a_idle_pol: assert property (p_idle_pol)
        else $error("idle serial clock not at chosen polarity");

    property p_rx_pair;
        @(posedge ref_clk) disable iff (!nrst)
        (done_p && lane == serial_port_pkg::LANE_ONE) |-> (rx_push && rx_ready && tx_pop);
    endproperty
    a_rx_pair: assert property (p_rx_pair)
        else $error("element sent without one stored");

    property p_abort;
        @(posedge ref_clk) disable iff (!nrst)
        abort_p |-> !tx_pop ##1 (st_r == serial_port_pkg::ST_IDLE && edge_r == '0);
    endproperty
    a_abort: assert property (p_abort)
        else $error("aborted element was dropped");
endmodule : serial_port_core

// ### core/serial_port_pkg.sv
package serial_port_pkg;
    // host clock and serial clock timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCK_HALF_NS   = 40;
    localparam int SCK_HALF_CYC  = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // build-time defaults
    localparam int DEF_LANES      = 1;
    localparam int DEF_WIDTH      = 8;
    localparam int DEF_FIFO_DEPTH = 16;
    localparam int ALT_FIFO_DEPTH = 256;
    localparam int DEF_SLAVES     = 1;
    localparam int MAX_SLAVES     = 32;
    localparam int HOST_WIDTH     = 32;

    // pin enable patterns
    localparam logic [3:0] OE_NONE   = 4'h0;
    localparam logic [3:0] OE_SINGLE = 4'h1;
    localparam logic [3:0] OE_SLAVE  = 4'h2;
    localparam logic [3:0] OE_DUAL   = 4'h3;
    localparam logic [3:0] OE_QUAD   = 4'hF;

    typedef enum logic [1:0] {LANE_ONE, LANE_TWO, LANE_FOUR} lane_mode_t;
    typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_GAP} state_t;

    typedef struct packed {
        logic                  enable;
        logic                  master;
        logic                  cpol;
        logic                  cpha;
        logic                  auto_ss;
        logic                  rx_dir;
        lane_mode_t            lanes;
        logic [MAX_SLAVES-1:0] ss_value;
    } cfg_t;

    typedef struct packed {
        logic busy;
        logic done;
        logic aborted;
        logic tx_empty;
    } stat_t;
endpackage : serial_port_pkg

// ### core/stream_fifo.sv
`timescale 1ns/1ps
module stream_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         nrst,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
            $error("fifo depth must be a power of two");
        end
    endgenerate

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0]   cnt_r, cnt_nxt;
    logic [W-1:0]  dat_r, dat_nxt;
    logic          push, pop;

    assign in_ready  = cnt_r != FULL;
    assign out_valid = cnt_r != '0;
    assign out_data  = dat_r;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wp_nxt  = push ? wp_r + 1'b1 : wp_r;
        rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        // head word may not be in memory yet: bypass it
        if (push && (cnt_r == '0 || (pop && cnt_r == 1)))
            dat_nxt = in_data;
        else
            dat_nxt = mem[rp_nxt];
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
            dat_r <= '0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
            dat_r <= dat_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push)
            mem[wp_r] <= in_data;
    end
endmodule : stream_fifo

// ### tb/flash_model.sv
`timescale 1ns/1ps
module flash_model (
    // serial pins
    input  wire logic sck,
    input  wire logic sel_n,
    input  wire logic mosi,
    output logic      miso
);
    logic [7:0] rx_sh = 8'h00;
    logic [7:0] tx_sh = 8'h96;
    int         bits  = 0;
    logic [7:0] got[$];
    initial miso = 1'b0;
    // clock mode 0 only: sample on rise, next bit out on fall
    always @(posedge sck) begin
        if (!sel_n) begin
            rx_sh = {rx_sh[6:0], mosi};
            bits++;
            if (bits == 8) begin
                got.push_back(rx_sh);
                bits = 0;
                tx_sh = 8'h96 + 8'(got.size());
            end
        end
    end
    always @(negedge sck) if (!sel_n) miso = tx_sh[7 - bits];
    always @(negedge sel_n) begin
        bits = 0;
        miso = tx_sh[7];
    end
    // released line shows the inverse so stale data cannot pass
    always @(posedge sel_n) miso = ~miso;
endmodule : flash_model

// ### tb/serial_port_core_tb_top.sv
`timescale 1ns/1ps
module serial_port_core_tb_top;
    logic                   ref_clk = 1'b0;
    logic                   nrst = 1'b0;
    serial_port_pkg::cfg_t  cfg;
    serial_port_pkg::stat_t stat;
    logic                   wr_valid, wr_ready, rd_valid, rd_ready, sck_in, sck_out, sck_oe;
    logic                   sel_in_n, miso, slv_mosi, ok;
    logic [31:0]            wr_data, rd_data;
    logic [0:0]             ss_n_out;
    logic [3:0]             io_out, io_oe;
    logic [7:0]             seen;
    int miscompares = 0, check_count = 0, done_cnt = 0, abort_cnt = 0, ss_rise = 0, n, k;

    always #5 ref_clk = ~ref_clk;
    serial_port_core #(.HALF_CYC(serial_port_pkg::SCK_HALF_CYC)) uut (
        .ref_clk(ref_clk), .nrst(nrst), .cfg(cfg), .stat(stat),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
        .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe),
        .slave_select_input(sel_in_n), .ss_n_out(ss_n_out),
        .io_in({2'b11, miso, slv_mosi}), .io_out(io_out), .io_oe(io_oe));
    flash_model partner (.sck(sck_out), .sel_n(ss_n_out[0]), .mosi(io_out[0]), .miso(miso));
    always @(posedge ref_clk) begin
        if (stat.done === 1'b1) done_cnt++;
        if (stat.aborted === 1'b1) abort_cnt++;
    end
    always @(posedge ss_n_out[0]) ss_rise++;

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task finish_test;
        $display("miscompares %0d check_count %0d", miscompares, check_count);
        if (miscompares == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test
    task put(input logic [7:0] d);
        ok = 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(negedge ref_clk);
            if (wr_ready === 1'b1) begin
                wr_valid = 1'b1;
                wr_data = {24'h0, d};
                ok = 1'b1;
            end
        end
        if (ok) begin
            @(negedge ref_clk);
            wr_valid = 1'b0;
        end
    endtask : put
    task get(input logic [7:0] exp);
        @(negedge ref_clk);
        for (int i = 0; i < 200 && rd_valid !== 1'b1; i++) @(negedge ref_clk);
        chk("rd_data", {24'h0, exp}, rd_data);
        rd_ready = 1'b1;
        @(negedge ref_clk);
        rd_ready = 1'b0;
    endtask : get
    task run(input logic on);
        cfg.ss_value = {31'h0, on};
        cfg.enable = on;
        repeat (3) @(negedge ref_clk);
        for (int i = 0; i < 2000 && !(stat.tx_empty === 1'b1 && stat.busy === 1'b0); i++)
            @(negedge ref_clk);
    endtask : run
    task t_reset_and_master;
        chk("reset pins", 8'h82, {ss_n_out, io_oe, sck_oe, wr_ready, rd_valid});
        cfg.master = 1'b1;
        put(8'hA5);
        put(8'h3C);
        ss_rise = 0;
        run(1'b1);
        chk("mosi 0", 8'hA5, partner.got[0]);
        chk("mosi 1", 8'h3C, partner.got[1]);
        chk("done", 2, done_cnt);
        chk("ss held", 0, {ss_rise, ss_n_out});
        chk("oe", {1'b1, serial_port_pkg::OE_SINGLE}, {sck_oe, io_oe});
        get(8'h96);
        get(8'h97);
    endtask : t_reset_and_master
    task t_fill_drain;
        run(1'b0);
        chk("ss off", 1, ss_n_out);
        n = 0;
        for (k = 0; k < 17; k++) begin
            put(8'h10 + 8'(k));
            if (ok) n++;
        end
        chk("accepted", 16, n);
        run(1'b1);
        for (k = 0; k < 16; k++) chk("mosi", 8'h10 + 8'(k), partner.got[2+k]);
        for (k = 0; k < 16; k++) get(8'h98 + 8'(k));
        chk("rx empty", 0, rd_valid);
        run(1'b0);
    endtask : t_fill_drain
    task t_polarity;
        cfg.cpol = 1'b1;
        run(1'b1);
        chk("idle high", 1, sck_out);
        cfg.cpol = 1'b0;
        run(1'b1);
        chk("idle low", 0, sck_out);
    endtask : t_polarity
    task sbits(input int cnt);
        for (int i = 0; i < cnt; i++) begin
            slv_mosi = k[7-i];
            #62.5 sck_in = 1'b1;
            seen = {seen[6:0], io_out[1]};
            #62.5 sck_in = 1'b0;
        end
    endtask : sbits
    task t_slave;
        cfg.master = 1'b0;
        run(1'b0);
        cfg.enable = 1'b1;
        put(8'h81);
        k = 8'h4D;
        sel_in_n = 1'b0;
        #100 sbits(3);
        sel_in_n = 1'b1;
        #200 chk("aborted", 1, abort_cnt);
        sel_in_n = 1'b0;
        #100 sbits(8);
        chk("miso resent", 8'h81, seen);
        // let the last falling edge pass the synchroniser before deselect
        #100 sel_in_n = 1'b1;
        get(8'h4D);
    endtask : t_slave

    initial begin
        #200000 miscompares++;
        finish_test();
    end
    initial begin
        cfg = '0;
        cfg.ss_value = '1;
        {wr_valid, rd_ready, sck_in, slv_mosi, wr_data} = '0;
        sel_in_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        nrst = 1'b1;
        @(negedge ref_clk);
        t_reset_and_master();
        t_fill_drain();
        t_polarity();
        t_slave();
        finish_test();
    end
endmodule : serial_port_core_tb_top
